/* gpp_pkg.sv */
// constants for the general-purpose and serial pin port block
// Behaviour
// RQ1 - control: direction bit 2n, pull-up 2n+1
// RQ2 - output direction forces pull-up off
// RQ3 - control and irq-enable cleared by power-on only
// RQ4 - output pins drive latch; read returns latch
// RQ5 - input pins read back synchronised pin level
// RQ6 - data latches never reset, keep contents
// RQ7 - software writes data before selecting output
// RQ8 - port B mirrors A on pins 31..16
// RQ9 - active-low level irq: OR of enabled low pins
// RQ10 - irq enable bit n masks port A pin n
// RQ11 - software reads port A data for source
// RQ12 - serial1 bit3 clock dir, bit2 clock data
// RQ13 - software stops serial1 clock before port use
// RQ14 - serial1 bit1 txd select, bit0 txd/rxd
// RQ15 - software clears transmit enable before break
// RQ16 - serial1 bit7 rx irq enable, 6..4 zero
// RQ17 - resets clear serial control bits, not data
// RQ18 - serial2 bit7 rts dir, bit6 rts data
// RQ19 - serial2 bit5 cts dir, bit4 cts data
// RQ20 - serial2 bit3 clock dir, bit2 clock data
// RQ21 - serial2 bit1 txd select, bit0; 15..8 zero
// RQ22 - software disables serial2 functions before port use
// RQ23 - software enables port only without PCI
// RQ24 - software sets irq source pins as input
// RQ25 - irq holds while any enabled pin low
package gpp_pkg;
    localparam int          PORT_W        = 16;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    // byte offsets of the register map
    localparam logic [7:0]  OFS_A_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_A_DATA    = 8'h04;
    localparam logic [7:0]  OFS_B_CTRL    = 8'h08;
    localparam logic [7:0]  OFS_B_DATA    = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_EN    = 8'h10;
    localparam logic [7:0]  OFS_SER1      = 8'h14;
    localparam logic [7:0]  OFS_SER2      = 8'h18;
    // reset values
    localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
    localparam logic [15:0] IRQ_EN_RST    = 16'h0000;
    // serial1 pin port fields
    localparam int          S1_RXF_IEN    = 7;
    localparam int          S1_CLK_DIR    = 3;
    localparam int          S1_CLK_VAL    = 2;
    localparam int          S1_TXD_DIR    = 1;
    localparam int          S1_LINE_VAL   = 0;
    // serial2 pin port fields
    localparam int          S2_RTS_DIR    = 7;
    localparam int          S2_RTS_VAL    = 6;
    localparam int          S2_CTS_DIR    = 5;
    localparam int          S2_CTS_VAL    = 4;
    localparam int          S2_CLK_DIR    = 3;
    localparam int          S2_CLK_VAL    = 2;
    localparam int          S2_TXD_DIR    = 1;
    localparam int          S2_LINE_VAL   = 0;
    // serial pins passed through the synchroniser
    localparam int          SER_PINS      = 6;
    localparam int          SP_SCK1       = 0;
    localparam int          SP_RXD1       = 1;
    localparam int          SP_RTS2       = 2;
    localparam int          SP_CTS2       = 3;
    localparam int          SP_SCK2       = 4;
    localparam int          SP_RXD2       = 5;
endpackage

/* gpp_sync.sv */
// two-stage synchroniser for a bundle of pin inputs
module gpp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

/* gpp_port.sv */
// general-purpose ports A/B, pin interrupt and serial pin-port registers
//
// Our own choices: the strobed register port and the placing of the registers.
module gpp_port (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic        manual_rst_in,
    input  wire logic        gpio_use_select_in,
    // register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    // port A pins 15..0
    input  wire logic [15:0] port_a_in,
    output logic      [15:0] port_a_out,
    output logic      [15:0] port_a_oe_out,
    output logic      [15:0] port_a_pullup_out,
    // port B pins 31..16
    input  wire logic [15:0] port_b_in,
    output logic      [15:0] port_b_out,
    output logic      [15:0] port_b_oe_out,
    output logic      [15:0] port_b_pullup_out,
    output logic             pin_irq_n_out,
    // first serial interface pins
    input  wire logic        sck1_in,
    output logic             sck1_out,
    output logic             sck1_oe_out,
    input  wire logic        rxd1_in,
    output logic             txd1_out,
    output logic             txd1_oe_out,
    output logic             receive_full_irq_en_out,
    // second serial interface pins
    input  wire logic        rts2_in,
    output logic             rts2_out,
    output logic             rts2_oe_out,
    input  wire logic        cts2_in,
    output logic             cts2_out,
    output logic             cts2_oe_out,
    input  wire logic        sck2_in,
    output logic             sck2_out,
    output logic             sck2_oe_out,
    input  wire logic        rxd2_in,
    output logic             txd2_out,
    output logic             txd2_oe_out
);
    // control registers (power-on reset only)
    logic [31:0] port_a_direction_ctrl_q;
    logic [31:0] port_b_direction_ctrl_q;
    logic [15:0] pin_interrupt_enable_q;
    // data latches, never reset
    logic [15:0] port_a_data_latch_q;
    logic [15:0] port_b_data_latch_q;
    // serial pin ports: control bits reset, value bits never reset
    logic        s1_rxf_ien_q;
    logic        s1_clk_dir_q;
    logic        s1_txd_dir_q;
    logic        s1_clk_val_q;
    logic        s1_line_val_q;
    logic        s2_rts_dir_q;
    logic        s2_cts_dir_q;
    logic        s2_clk_dir_q;
    logic        s2_txd_dir_q;
    logic        s2_rts_val_q;
    logic        s2_cts_val_q;
    logic        s2_clk_val_q;
    logic        s2_line_val_q;

    logic [15:0] pin_a_sync;
    logic [15:0] pin_b_sync;
    logic [gpp_pkg::SER_PINS-1:0] ser_async;
    logic [gpp_pkg::SER_PINS-1:0] ser_sync;

    logic        wr_a_ctrl;
    logic        wr_a_data;
    logic        wr_b_ctrl;
    logic        wr_b_data;
    logic        wr_irq_en;
    logic        wr_ser1;
    logic        wr_ser2;
    logic [15:0] dir_a;
    logic [15:0] dir_b;
    logic [31:0] rdata_d;

    // direction bits sit at even positions
    function automatic logic [15:0] dir_bits(input logic [31:0] ctrl);
        logic [15:0] r;
        r = '0;
        for (int n = 0; n < 16; n++) begin
            r[n] = ctrl[2*n]; // RQ1
        end
        return r;
    endfunction

    // pull-up selects sit at odd positions, blocked on outputs
    function automatic logic [15:0] pullup_bits(input logic [31:0] ctrl);
        logic [15:0] r;
        r = '0;
        for (int n = 0; n < 16; n++) begin
            r[n] = ctrl[2*n+1] & ~ctrl[2*n]; // RQ1 RQ2
        end
        return r;
    endfunction

    // outputs read the latch, inputs read the sampled pin
    function automatic logic [15:0] port_read(input logic [15:0] dir,
                                              input logic [15:0] latch,
                                              input logic [15:0] pin);
        return (dir & latch) | (~dir & pin);
    endfunction

    // every pin is asynchronous to clk_in
    gpp_sync #(
        .W (16)
    ) u_sync_a (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .async_in (port_a_in),
        .sync_out (pin_a_sync)
    );

    gpp_sync #(
        .W (16)
    ) u_sync_b (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .async_in (port_b_in),
        .sync_out (pin_b_sync)
    );

    always_comb begin
        ser_async                   = '0;
        ser_async[gpp_pkg::SP_SCK1] = sck1_in;
        ser_async[gpp_pkg::SP_RXD1] = rxd1_in;
        ser_async[gpp_pkg::SP_RTS2] = rts2_in;
        ser_async[gpp_pkg::SP_CTS2] = cts2_in;
        ser_async[gpp_pkg::SP_SCK2] = sck2_in;
        ser_async[gpp_pkg::SP_RXD2] = rxd2_in;
    end

    gpp_sync #(
        .W (gpp_pkg::SER_PINS)
    ) u_sync_ser (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .async_in (ser_async),
        .sync_out (ser_sync)
    );

    assign wr_a_ctrl = wr_in && (addr_in == gpp_pkg::OFS_A_CTRL);
    assign wr_a_data = wr_in && (addr_in == gpp_pkg::OFS_A_DATA);
    assign wr_b_ctrl = wr_in && (addr_in == gpp_pkg::OFS_B_CTRL);
    assign wr_b_data = wr_in && (addr_in == gpp_pkg::OFS_B_DATA);
    assign wr_irq_en = wr_in && (addr_in == gpp_pkg::OFS_IRQ_EN);
    assign wr_ser1   = wr_in && (addr_in == gpp_pkg::OFS_SER1);
    assign wr_ser2   = wr_in && (addr_in == gpp_pkg::OFS_SER2);
    assign dir_a     = dir_bits(port_a_direction_ctrl_q);
    assign dir_b     = dir_bits(port_b_direction_ctrl_q);

    // manual reset deliberately leaves these untouched
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            port_a_direction_ctrl_q <= gpp_pkg::CTRL_RST; // RQ3
            port_b_direction_ctrl_q <= gpp_pkg::CTRL_RST; // RQ3 RQ8
            pin_interrupt_enable_q  <= gpp_pkg::IRQ_EN_RST; // RQ3
        end else begin
            if (wr_a_ctrl) begin
                port_a_direction_ctrl_q <= wdata_in;
            end
            if (wr_b_ctrl) begin
                port_b_direction_ctrl_q <= wdata_in; // RQ8
            end
            if (wr_irq_en) begin
                pin_interrupt_enable_q <= wdata_in[15:0]; // RQ10
            end
        end
    end

    // no reset term at all: contents survive every reset
    always_ff @(posedge clk_in) begin
        if (wr_a_data) begin
            port_a_data_latch_q <= wdata_in[15:0]; // RQ4 RQ6
        end
        if (wr_b_data) begin
            port_b_data_latch_q <= wdata_in[15:0]; // RQ6 RQ8
        end
    end

    // serial control bits: cleared by either reset
    always_ff @(posedge clk_in) begin
        if (!rstn_in || manual_rst_in) begin
            s1_rxf_ien_q <= 1'b0; // RQ17
            s1_clk_dir_q <= 1'b0; // RQ17
            s1_txd_dir_q <= 1'b0; // RQ17
            s2_rts_dir_q <= 1'b0; // RQ17
            s2_cts_dir_q <= 1'b0; // RQ17
            s2_clk_dir_q <= 1'b0; // RQ17
            s2_txd_dir_q <= 1'b0; // RQ17
        end else begin
            if (wr_ser1) begin
                s1_rxf_ien_q <= wdata_in[gpp_pkg::S1_RXF_IEN]; // RQ16
                s1_clk_dir_q <= wdata_in[gpp_pkg::S1_CLK_DIR]; // RQ12
                s1_txd_dir_q <= wdata_in[gpp_pkg::S1_TXD_DIR]; // RQ14
            end
            if (wr_ser2) begin
                s2_rts_dir_q <= wdata_in[gpp_pkg::S2_RTS_DIR]; // RQ18
                s2_cts_dir_q <= wdata_in[gpp_pkg::S2_CTS_DIR]; // RQ19
                s2_clk_dir_q <= wdata_in[gpp_pkg::S2_CLK_DIR]; // RQ20
                s2_txd_dir_q <= wdata_in[gpp_pkg::S2_TXD_DIR]; // RQ21
            end
        end
    end

    // serial value bits have no reset and keep their contents through either reset
    always_ff @(posedge clk_in) begin
        if (wr_ser1) begin
            s1_clk_val_q  <= wdata_in[gpp_pkg::S1_CLK_VAL]; // RQ12 RQ17
            s1_line_val_q <= wdata_in[gpp_pkg::S1_LINE_VAL]; // RQ14 RQ17
        end
        if (wr_ser2) begin
            s2_rts_val_q  <= wdata_in[gpp_pkg::S2_RTS_VAL]; // RQ18
            s2_cts_val_q  <= wdata_in[gpp_pkg::S2_CTS_VAL]; // RQ19
            s2_clk_val_q  <= wdata_in[gpp_pkg::S2_CLK_VAL]; // RQ20
            s2_line_val_q <= wdata_in[gpp_pkg::S2_LINE_VAL]; // RQ21
        end
    end

    // read mux; unmapped offsets and reserved bits return zero
    always_comb begin
        rdata_d = '0;
        case (addr_in)
            gpp_pkg::OFS_A_CTRL: begin
                rdata_d = port_a_direction_ctrl_q;
            end
            gpp_pkg::OFS_A_DATA: begin
                rdata_d[15:0] = port_read(dir_a, port_a_data_latch_q, pin_a_sync); // RQ4 RQ5
            end
            gpp_pkg::OFS_B_CTRL: begin
                rdata_d = port_b_direction_ctrl_q;
            end
            gpp_pkg::OFS_B_DATA: begin
                rdata_d[15:0] = port_read(dir_b, port_b_data_latch_q, pin_b_sync); // RQ8
            end
            gpp_pkg::OFS_IRQ_EN: begin
                rdata_d[15:0] = pin_interrupt_enable_q;
            end
            gpp_pkg::OFS_SER1: begin
                rdata_d[gpp_pkg::S1_RXF_IEN]  = s1_rxf_ien_q; // RQ16
                rdata_d[gpp_pkg::S1_CLK_DIR]  = s1_clk_dir_q;
                rdata_d[gpp_pkg::S1_CLK_VAL]  = ser_sync[gpp_pkg::SP_SCK1]; // RQ12
                rdata_d[gpp_pkg::S1_TXD_DIR]  = s1_txd_dir_q;
                rdata_d[gpp_pkg::S1_LINE_VAL] = ser_sync[gpp_pkg::SP_RXD1]; // RQ14
            end
            gpp_pkg::OFS_SER2: begin
                rdata_d[gpp_pkg::S2_RTS_DIR]  = s2_rts_dir_q;
                rdata_d[gpp_pkg::S2_RTS_VAL]  = ser_sync[gpp_pkg::SP_RTS2]; // RQ18
                rdata_d[gpp_pkg::S2_CTS_DIR]  = s2_cts_dir_q;
                rdata_d[gpp_pkg::S2_CTS_VAL]  = ser_sync[gpp_pkg::SP_CTS2]; // RQ19
                rdata_d[gpp_pkg::S2_CLK_DIR]  = s2_clk_dir_q;
                rdata_d[gpp_pkg::S2_CLK_VAL]  = ser_sync[gpp_pkg::SP_SCK2]; // RQ20
                rdata_d[gpp_pkg::S2_TXD_DIR]  = s2_txd_dir_q;
                rdata_d[gpp_pkg::S2_LINE_VAL] = ser_sync[gpp_pkg::SP_RXD2]; // RQ21
            end
            default: begin
                rdata_d = '0;
            end
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            rdata_out <= '0;
        end else if (rd_in) begin
            rdata_out <= rdata_d;
        end else begin
            rdata_out <= '0;
        end
    end

    // registered pin drivers; port use gated by the bus-control select
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            port_a_out        <= '0;
            port_a_oe_out     <= '0;
            port_a_pullup_out <= '0;
            port_b_out        <= '0;
            port_b_oe_out     <= '0;
            port_b_pullup_out <= '0;
        end else begin
            port_a_out        <= port_a_data_latch_q & dir_a; // RQ4
            port_a_oe_out     <= dir_a & {16{gpio_use_select_in}}; // RQ4
            port_a_pullup_out <= pullup_bits(port_a_direction_ctrl_q) &
                                 {16{gpio_use_select_in}}; // RQ2
            port_b_out        <= port_b_data_latch_q & dir_b; // RQ8
            port_b_oe_out     <= dir_b & {16{gpio_use_select_in}}; // RQ8
            port_b_pullup_out <= pullup_bits(port_b_direction_ctrl_q) &
                                 {16{gpio_use_select_in}}; // RQ2 RQ8
        end
    end

    // level request, re-evaluated every cycle so it tracks the pins
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pin_irq_n_out <= 1'b1;
        end else begin
            pin_irq_n_out <= ~|(pin_interrupt_enable_q & ~pin_a_sync); // RQ9 RQ10 RQ25
        end
    end

    // value bits are driven only when their direction bit is set
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            sck1_out                <= 1'b0;
            sck1_oe_out             <= 1'b0;
            txd1_out                <= 1'b0;
            txd1_oe_out             <= 1'b0;
            receive_full_irq_en_out <= 1'b0;
            rts2_out                <= 1'b0;
            rts2_oe_out             <= 1'b0;
            cts2_out                <= 1'b0;
            cts2_oe_out             <= 1'b0;
            sck2_out                <= 1'b0;
            sck2_oe_out             <= 1'b0;
            txd2_out                <= 1'b0;
            txd2_oe_out             <= 1'b0;
        end else begin
            sck1_out                <= s1_clk_dir_q & s1_clk_val_q; // RQ12
            sck1_oe_out             <= s1_clk_dir_q; // RQ12
            txd1_out                <= s1_txd_dir_q & s1_line_val_q; // RQ14
            txd1_oe_out             <= s1_txd_dir_q; // RQ14
            receive_full_irq_en_out <= s1_rxf_ien_q; // RQ16
            rts2_out                <= s2_rts_dir_q & s2_rts_val_q; // RQ18
            rts2_oe_out             <= s2_rts_dir_q; // RQ18
            cts2_out                <= s2_cts_dir_q & s2_cts_val_q; // RQ19
            cts2_oe_out             <= s2_cts_dir_q; // RQ19
            sck2_out                <= s2_clk_dir_q & s2_clk_val_q; // RQ20
            sck2_oe_out             <= s2_clk_dir_q; // RQ20
            txd2_out                <= s2_txd_dir_q & s2_line_val_q; // RQ21
            txd2_oe_out             <= s2_txd_dir_q; // RQ21
        end
    end
endmodule

/* gpp_props.sv */
// concurrent checks on the ports of the pin port block
module gpp_props (
    input wire logic        clk_in,
    input wire logic        rstn_in,
    input wire logic        manual_rst_in,
    input wire logic [7:0]  addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic [15:0] port_a_in,
    input wire logic [15:0] port_a_oe_out,
    input wire logic [15:0] port_a_pullup_out,
    input wire logic [15:0] port_b_oe_out,
    input wire logic [15:0] port_b_pullup_out,
    input wire logic        pin_irq_n_out,
    input wire logic        sck1_oe_out,
    input wire logic        txd1_oe_out,
    input wire logic        rts2_oe_out,
    input wire logic        cts2_oe_out,
    input wire logic        sck2_oe_out,
    input wire logic        txd2_oe_out,
    input wire logic        receive_full_irq_en_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    logic ser_oe;
    assign ser_oe = sck1_oe_out | txd1_oe_out | rts2_oe_out | cts2_oe_out
                  | sck2_oe_out | txd2_oe_out;
    // three edges of pin-to-request latency fit inside four high samples
    sequence s_all_high;
        port_a_in == 16'hffff [*4];
    endsequence
    sequence s_wr_rd(a);
        wr_in && addr_in == a ##1 rd_in && addr_in == a;
    endsequence
    a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data not zero outside answer");
    a_pull_off: assert property ((port_a_oe_out & port_a_pullup_out) == 16'h0 &&
        (port_b_oe_out & port_b_pullup_out) == 16'h0) else $error("pull-up while driving");
    a_ctrl_a_rw: assert property (s_wr_rd(gpp_pkg::OFS_A_CTRL) |=>
        rdata_out == $past(wdata_in, 2)) else $error("port a control readback");
    a_ctrl_b_rw: assert property (s_wr_rd(gpp_pkg::OFS_B_CTRL) |=>
        rdata_out == $past(wdata_in, 2)) else $error("port b control readback");
    a_s1_rsvd: assert property ($past(rd_in && addr_in == gpp_pkg::OFS_SER1) |->
        rdata_out[31:8] == 24'h0 && rdata_out[6:4] == 3'h0) else $error("serial1 reserved");
    a_s2_rsvd: assert property ($past(rd_in && addr_in == gpp_pkg::OFS_SER2) |->
        rdata_out[31:8] == 24'h0) else $error("serial2 reserved bits set");
    a_unmapped_zero: assert property ($past(rd_in && addr_in > 8'h1b) |-> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_irq_high: assert property (s_all_high |-> pin_irq_n_out)
        else $error("pin request with all pins high");
    a_por_clear: assert property ($past(!rstn_in) |-> !ser_oe &&
        port_a_oe_out == 16'h0 && port_b_oe_out == 16'h0 && pin_irq_n_out &&
        !receive_full_irq_en_out) else $error("outputs not cleared by power-on reset");
    a_manual_clr: assert property (manual_rst_in |->
        ##2 (!ser_oe && !receive_full_irq_en_out)) else $error("serial oe kept by manual reset");
endmodule

bind gpp_port gpp_props gpp_props_inst (
    .clk_in(clk_in), .rstn_in(rstn_in), .manual_rst_in(manual_rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .port_a_in(port_a_in), .port_a_oe_out(port_a_oe_out), .port_a_pullup_out(port_a_pullup_out),
    .port_b_oe_out(port_b_oe_out), .port_b_pullup_out(port_b_pullup_out),
    .pin_irq_n_out(pin_irq_n_out), .sck1_oe_out(sck1_oe_out), .txd1_oe_out(txd1_oe_out),
    .rts2_oe_out(rts2_oe_out), .cts2_oe_out(cts2_oe_out), .sck2_oe_out(sck2_oe_out),
    .txd2_oe_out(txd2_oe_out), .receive_full_irq_en_out(receive_full_irq_en_out));

/* gpp_pins.sv */
// board-side model of the pins around the port block
module gpp_pins (
    input  wire logic        clk_in,
    input  wire logic [15:0] a_out_in,
    input  wire logic [15:0] a_oe_in,
    input  wire logic [15:0] a_pu_in,
    input  wire logic [15:0] a_ext_in,
    input  wire logic [15:0] a_flt_in,
    output logic      [15:0] a_lvl_out,
    input  wire logic [15:0] b_out_in,
    input  wire logic [15:0] b_oe_in,
    input  wire logic [15:0] b_ext_in,
    output logic      [15:0] b_lvl_out,
    input  wire logic [5:0]  s_out_in,
    input  wire logic [5:0]  s_oe_in,
    input  wire logic [5:0]  s_ext_in,
    output logic      [5:0]  s_lvl_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog = 1'b0;
    // a floating pin without pull-up wanders rather than keeping its last level
    always_ff @(posedge clk_in) tog <= ~tog;
    assign a_lvl_out = (a_oe_in & a_out_in) | (~a_oe_in & ~a_flt_in & a_ext_in)
                     | (~a_oe_in & a_flt_in & (a_pu_in | {16{tog}}));
    assign b_lvl_out = (b_oe_in & b_out_in) | (~b_oe_in & b_ext_in);
    assign s_lvl_out = (s_oe_in & s_out_in) | (~s_oe_in & s_ext_in);
endmodule

/* tb_top.sv */
// self-checking bench for the pin port block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0;
    logic        rstn = 1'b0;
    logic        man = 1'b0;
    logic        use_sel = 1'b1;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  addr = 8'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] wv;
    logic [15:0] po [2];
    logic [15:0] poe [2];
    logic [15:0] ppu [2];
    logic [15:0] lv [2];
    logic [15:0] ext [2] = '{16'h0, 16'h0};
    logic [15:0] flt = 16'h0;
    logic [5:0]  sx = 6'h0;
    logic [5:0]  sl;
    wire  [12:0] sv;
    logic        irq_n;
    logic [31:0] ctl [2] = '{32'h0, 32'h0};
    logic [15:0] dat [2];
    logic [15:0] ien = 16'h0;
    logic [7:0]  s1 = 8'h0;
    logic [7:0]  s2 = 8'h0;
    integer      seed = 32'hca73c484;
    int          n_mismatch = 0;
    int          num_checks = 0;

    always #10 clk_in = ~clk_in;
    gpp_port gpp_port_inst (
        .clk_in(clk_in), .rstn_in(rstn), .manual_rst_in(man), .gpio_use_select_in(use_sel),
        .addr_in(addr), .wdata_in(wdat), .wr_in(wr), .rd_in(rd), .rdata_out(rdat),
        .port_a_in(lv[0]), .port_a_out(po[0]), .port_a_oe_out(poe[0]), .port_a_pullup_out(ppu[0]),
        .port_b_in(lv[1]), .port_b_out(po[1]), .port_b_oe_out(poe[1]), .port_b_pullup_out(ppu[1]),
        .pin_irq_n_out(irq_n), .sck1_in(sl[0]), .sck1_out(sv[11]), .sck1_oe_out(sv[12]),
        .rxd1_in(sl[1]), .txd1_out(sv[9]), .txd1_oe_out(sv[10]), .receive_full_irq_en_out(sv[0]),
        .rts2_in(sl[2]), .rts2_out(sv[7]), .rts2_oe_out(sv[8]), .cts2_in(sl[3]),
        .cts2_out(sv[5]), .cts2_oe_out(sv[6]), .sck2_in(sl[4]), .sck2_out(sv[3]),
        .sck2_oe_out(sv[4]), .rxd2_in(sl[5]), .txd2_out(sv[1]), .txd2_oe_out(sv[2]));

    gpp_pins gpp_pins_inst (
        .clk_in(clk_in), .a_out_in(po[0]), .a_oe_in(poe[0]), .a_pu_in(ppu[0]),
        .a_ext_in(ext[0]), .a_flt_in(flt), .a_lvl_out(lv[0]), .b_out_in(po[1]),
        .b_oe_in(poe[1]), .b_ext_in(ext[1]), .b_lvl_out(lv[1]),
        .s_out_in({1'b0, sv[3], sv[5], sv[7], 1'b0, sv[11]}),
        .s_oe_in({1'b0, sv[4], sv[6], sv[8], 1'b0, sv[12]}), .s_ext_in(sx), .s_lvl_out(sl));

    function automatic logic [15:0] fld(input logic [31:0] c, input int o);
        for (int i = 0; i < 16; i++) fld[i] = c[2*i+o];
    endfunction
    function automatic logic [15:0] pin(input int p);
        logic [15:0] d;
        logic [15:0] f;
        d = fld(ctl[p], 0) & {16{use_sel}};
        f = (p == 0) ? flt : 16'h0;
        return (d & dat[p]) | (~d & ~f & ext[p]) | (~d & f & fld(ctl[p], 1));
    endfunction
    function automatic logic [15:0] rv(input int p);
        return (fld(ctl[p], 0) & dat[p]) | (~fld(ctl[p], 0) & pin(p));
    endfunction

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr <= w;
        rd <= r;
        addr <= a;
        wdat <= d;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        cyc(1'b0, 1'b1, a, 32'h0);
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        chk(rdat, e);
    endtask
    task automatic chk_all;
        logic [15:0] dr;
        repeat (4) cyc(1'b0, 1'b0, 8'h0, 32'h0);
        rdc(gpp_pkg::OFS_A_CTRL, ctl[0]);
        rdc(gpp_pkg::OFS_B_CTRL, ctl[1]);
        rdc(gpp_pkg::OFS_A_DATA, 32'(rv(0)));
        rdc(gpp_pkg::OFS_B_DATA, 32'(rv(1)));
        rdc(gpp_pkg::OFS_IRQ_EN, 32'(ien));
        rdc(gpp_pkg::OFS_SER1, {24'h0, s1[7], 3'h0, s1[3],
            s1[3] ? s1[2] : sx[0], s1[1], sx[1]});
        rdc(gpp_pkg::OFS_SER2, {24'h0, s2[7], s2[7] ? s2[6] : sx[2], s2[5], s2[5] ? s2[4] : sx[3],
            s2[3], s2[3] ? s2[2] : sx[4], s2[1], sx[5]});
        rdc(8'h1c, 32'h0);
        for (int p = 0; p < 2; p++) begin
            dr = fld(ctl[p], 0);
            chk({po[p], poe[p]}, {dat[p] & dr, dr & {16{use_sel}}});
            chk(32'(ppu[p]), 32'(fld(ctl[p], 1) & ~dr & {16{use_sel}}));
        end
        chk(32'(irq_n), 32'(~|(ien & ~pin(0))));
        chk(32'(sv), 32'({s1[3], s1[3] & s1[2], s1[1],
            s1[1] & s1[0], s2[7], s2[7] & s2[6], s2[5], s2[5] & s2[4], s2[3], s2[3] & s2[2],
            s2[1], s2[1] & s2[0], s1[7]}));
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge clk_in);
        rstn <= 1'b1;
        chk_all();
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_in);
            ext[0] <= (i == 0) ? 16'hffff : 16'($random(seed));
            ext[1] <= 16'($random(seed));
            sx <= 6'($random(seed));
            // pull-up cases need the port enabled, else a floating pin wanders
            flt <= (i > 9) ? 16'hffff : 16'h0;
            use_sel <= (i < 3 || i > 9) | 1'($random(seed));
            dat[0] = 16'($random(seed));
            dat[1] = 16'($random(seed));
            cyc(1'b1, 1'b0, gpp_pkg::OFS_A_DATA, 32'(dat[0]));
            cyc(1'b1, 1'b0, gpp_pkg::OFS_B_DATA, 32'(dat[1]));
            ien = 16'($random(seed));
            cyc(1'b1, 1'b0, gpp_pkg::OFS_IRQ_EN, 32'(ien));
            wv = $random(seed);
            cyc(1'b1, 1'b0, gpp_pkg::OFS_SER1, wv);
            s1 = wv[7:0] & 8'h8f;
            wv = $random(seed);
            cyc(1'b1, 1'b0, gpp_pkg::OFS_SER2, wv);
            s2 = wv[7:0];
            ctl[1] = $random(seed);
            cyc(1'b1, 1'b0, gpp_pkg::OFS_B_CTRL, ctl[1]);
            rdc(gpp_pkg::OFS_B_CTRL, ctl[1]);
            ctl[0] = (i == 0) ? 32'h0 : (i == 10) ? 32'haaaaaaaa :
                     (i == 11) ? '1 : $random(seed);
            cyc(1'b1, 1'b0, gpp_pkg::OFS_A_CTRL, ctl[0]);
            rdc(gpp_pkg::OFS_A_CTRL, ctl[0]);
            chk_all();
            $display("test random %0d done", i);
        end
        @(posedge clk_in);
        flt <= 16'h0;
        man <= 1'b1;
        @(posedge clk_in);
        man <= 1'b0;
        s1 = s1 & 8'h05;
        s2 = s2 & 8'h55;
        chk_all();
        $display("test manual reset done");
        @(posedge clk_in);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_in);
        rstn <= 1'b1;
        ctl[0] = 32'h0;
        ctl[1] = 32'h0;
        ien = 16'h0;
        s1 = s1 & 8'h05;
        s2 = s2 & 8'h55;
        chk_all();
        ctl[0] = 32'h55555555;
        ctl[1] = 32'h55555555;
        cyc(1'b1, 1'b0, gpp_pkg::OFS_A_CTRL, ctl[0]);
        cyc(1'b1, 1'b0, gpp_pkg::OFS_B_CTRL, ctl[1]);
        chk_all();
        $display("test power-on reset done");
        summarize();
    end
endmodule
